// file: shared/evt_timer_pkg.sv
// package: register map, field positions, reset values and timing for the event counter timer
package evt_timer_pkg;
  // register word offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_IOCTRL = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_PRESCALE = 8'h0c;
  localparam logic [7:0] OFF_MAIN = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_PORT_OUT = 8'h1c;
  // control register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_STOP_BIT = 2;
  localparam int CTRL_STATUS_BIT = 1;
  // io control register fields
  localparam int IOC_EDGE_BIT = 0;
  localparam int IOC_OUTEN_BIT = 2;
  localparam int IOC_PINSEL_BIT = 3;
  localparam int IOC_FILT_LO_BIT = 4;
  localparam int IOC_FILT_HI_BIT = 5;
  // interrupt status bits
  localparam int IRQ_UNDERFLOW_BIT = 0;
  // reset values
  localparam logic [7:0] RST_COUNT = 8'hff;
  localparam logic [7:0] RST_IOCTRL = 8'h00;
  // filter: samples that must agree
  localparam int FILT_SAMPLES = 3;
  // filter sampling periods in system clocks (coarse choices)
  localparam logic [7:0] FILT_DIV_FAST = 8'h01;
  localparam logic [7:0] FILT_DIV_MID = 8'h08;
  localparam logic [7:0] FILT_DIV_SLOW = 8'h20;

  typedef struct packed {
    logic filtHigh;
    logic filtLow;
    logic pinSel;
    logic outEnable;
    logic edgeSel;
  } io_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : evt_timer_pkg

// file: hw/evt_input_filter.sv
// input stage: pin select, digital noise filter and active edge detector
`timescale 1ns/1ps
module evt_input_filter (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic pinA,
  input wire logic pinB,
  input wire evt_timer_pkg::io_cfg_t cfg,
  output logic level,
  output logic eventPulse
);
  typedef enum logic [2:0] {
    FS_FAST = 3'b001,
    FS_MID = 3'b010,
    FS_SLOW = 3'b100
  } filt_rate_t;

  logic [7:0] divCnt_r;
  logic [evt_timer_pkg::FILT_SAMPLES-1:0] samp_r;
  logic level_r;
  logic prevLevel_r;
  filt_rate_t rate;
  logic [7:0] divLimit;
  logic filtOn;
  logic rawPin;
  logic sampleTick;
  logic allHigh;
  logic allLow;
  logic levelNxt;
  logic edgeSeen;

  assign rawPin = cfg.pinSel ? pinB : pinA;
  assign filtOn = cfg.filtLow | cfg.filtHigh;
  assign rate = cfg.filtHigh ? (cfg.filtLow ? FS_SLOW : FS_MID) : FS_FAST;
  assign divLimit = (rate == FS_SLOW) ? evt_timer_pkg::FILT_DIV_SLOW :
                    (rate == FS_MID) ? evt_timer_pkg::FILT_DIV_MID : evt_timer_pkg::FILT_DIV_FAST;
  assign sampleTick = (divCnt_r >= divLimit - 8'h01);
  assign allHigh = &samp_r;
  assign allLow = ~|samp_r;
  assign levelNxt = !filtOn ? rawPin : (allHigh ? 1'b1 : (allLow ? 1'b0 : level_r));
  // edge select: 0 rising, 1 falling
  assign edgeSeen = cfg.edgeSel ? (prevLevel_r & ~level_r) : (~prevLevel_r & level_r);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_r <= 8'h00;
      samp_r <= '0;
    end else begin
      divCnt_r <= sampleTick ? 8'h00 : divCnt_r + 8'h01;
      if (sampleTick) begin
        samp_r <= {samp_r[evt_timer_pkg::FILT_SAMPLES-2:0], rawPin};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      level_r <= 1'b0;
      prevLevel_r <= 1'b0;
    end else begin
      level_r <= levelNxt;
      prevLevel_r <= level_r;
    end
  end

  assign level = level_r;
  assign eventPulse = edgeSeen;
endmodule : evt_input_filter

// file: hw/evt_down_counter.sv
// one reloadable down counter stage with underflow pulse
`timescale 1ns/1ps
module evt_down_counter #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  output logic [WIDTH-1:0] count,
  output logic underflow
);
  if (WIDTH < 2 || WIDTH > 16) begin : gWidthCheck
    $error("evt_down_counter: WIDTH out of range");
  end

  logic [WIDTH-1:0] reload_r;
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic atZero;

  assign atZero = (count_r == '0);
  assign underflow = tick & atZero & ~load;
  // reload on underflow and carry on counting
  assign count_nxt = load ? loadValue : (tick ? (atZero ? reload_r : count_r - 1'b1) : count_r);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reload_r <= {WIDTH{1'b1}};
      count_r <= {WIDTH{1'b1}};
    end else begin
      if (load) begin
        reload_r <= loadValue;
      end
      count_r <= count_nxt;
    end
  end

  assign count = count_r;
endmodule : evt_down_counter

// file: hw/event_counter_timer.sv
// event counter timer: register slave, prescaler and main counter cascade, pulse output, interrupt
`timescale 1ns/1ps
// Overview of operation
// - count source is active edges of the external signal on the event pin
// - decrement per event; on underflow reload and continue counting
// - events per underflow equal (prescaler+1) times (main+1)
// - writing one to the run bit starts counting
// - writing zero to the run bit halts counting
// - writing one to the force stop bit halts counting
// - every main counter underflow sets the interrupt status; timerIrq rises only while the mask bit is set
// - reading prescaler and main count registers returns current counts
// - count write while stopped loads reload register and counter
// - count write while running also loads reload register and counter
// - edge polarity bit picks rising or falling active edge
// - pin select bit picks which of two pins carries the event
// - output enable bit toggles inverted pulse pin at each underflow
// - filter bits enable the noise filter and choose its sample rate
// - writing the mode register sets pulse pin to its starting level
// - event pin still feeds the external interrupt line while counting
module event_counter_timer (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic portPinAltA,
  input wire logic portPinAltB,
  output logic externalInterruptLine,
  output logic invertedPulsePin,
  output logic invertedPulseOe,
  output logic timerIrq
);
  //////////////////////////////////////////////////////////////////////////////
  evt_timer_pkg::reg_req_t req;
  evt_timer_pkg::io_cfg_t ioCfg_r;
  logic run_r;
  logic pulseLevel_r;
  logic portOut_r;
  logic irqStatus_r;
  logic irqMask_r;
  logic [31:0] rdata_r;
  logic [7:0] preCount;
  logic [7:0] mainCount;
  logic preUnder;
  logic mainUnder;
  logic evtPulse;
  logic evtLevel;
  logic selCtrl;
  logic selIoc;
  logic selMode;
  logic selPre;
  logic selMain;
  logic selStat;
  logic selMask;
  logic selPort;
  logic wrCtrl;
  logic wrPre;
  logic wrMain;
  logic runNxt;
  logic preTick;
  logic irqNxt;
  logic [31:0] rdMux;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  assign selCtrl = (req.addr == evt_timer_pkg::OFF_CTRL);
  assign selIoc = (req.addr == evt_timer_pkg::OFF_IOCTRL);
  assign selMode = (req.addr == evt_timer_pkg::OFF_MODE);
  assign selPre = (req.addr == evt_timer_pkg::OFF_PRESCALE);
  assign selMain = (req.addr == evt_timer_pkg::OFF_MAIN);
  assign selStat = (req.addr == evt_timer_pkg::OFF_IRQ_STATUS);
  assign selMask = (req.addr == evt_timer_pkg::OFF_IRQ_MASK);
  assign selPort = (req.addr == evt_timer_pkg::OFF_PORT_OUT);
  assign wrCtrl = req.wr & selCtrl;
  assign wrPre = req.wr & selPre;
  assign wrMain = req.wr & selMain;

  //////////////////////////////////////////////////////////////////////////////
  // run control: stop bit wins over run bit in the same write
  assign runNxt = !wrCtrl ? run_r :
                  req.wdata[evt_timer_pkg::CTRL_STOP_BIT] ? 1'b0 :
                  req.wdata[evt_timer_pkg::CTRL_RUN_BIT];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      run_r <= 1'b0;
    end else begin
      run_r <= runNxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ioCfg_r <= evt_timer_pkg::io_cfg_t'(evt_timer_pkg::RST_IOCTRL[4:0]);
    end else if (req.wr && selIoc) begin
      ioCfg_r <= '{filtHigh: req.wdata[evt_timer_pkg::IOC_FILT_HI_BIT],
                   filtLow: req.wdata[evt_timer_pkg::IOC_FILT_LO_BIT],
                   pinSel: req.wdata[evt_timer_pkg::IOC_PINSEL_BIT],
                   outEnable: req.wdata[evt_timer_pkg::IOC_OUTEN_BIT],
                   edgeSel: req.wdata[evt_timer_pkg::IOC_EDGE_BIT]};
    end
  end

  evt_input_filter uFilter (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pinA(portPinAltA),
    .pinB(portPinAltB),
    .cfg(ioCfg_r),
    .level(evtLevel),
    .eventPulse(evtPulse)
  );

  // pin keeps feeding the external interrupt line regardless of counting
  assign externalInterruptLine = evtLevel;

  //////////////////////////////////////////////////////////////////////////////
  // cascade: prescaler counts events, main counts prescaler underflows
  assign preTick = run_r & evtPulse;

  evt_down_counter #(.WIDTH(8)) uPre (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick(preTick),
    .load(wrPre),
    .loadValue(req.wdata[7:0]),
    .count(preCount),
    .underflow(preUnder)
  );

  evt_down_counter #(.WIDTH(8)) uMain (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick(preUnder),
    .load(wrMain),
    .loadValue(req.wdata[7:0]),
    .count(mainCount),
    .underflow(mainUnder)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pulse output, inverted polarity, toggles per underflow
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pulseLevel_r <= 1'b1;
      portOut_r <= 1'b0;
    end else begin
      if (req.wr && selMode) begin
        pulseLevel_r <= 1'b1;
      end else if (mainUnder) begin
        pulseLevel_r <= ~pulseLevel_r;
      end
      if (req.wr && selPort) begin
        portOut_r <= req.wdata[0];
      end
    end
  end

  assign invertedPulsePin = ioCfg_r.outEnable ? pulseLevel_r : portOut_r;
  assign invertedPulseOe = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // interrupt: set wins over write-one-to-clear
  assign irqNxt = mainUnder | (irqStatus_r & ~(req.wr & selStat &
                  req.wdata[evt_timer_pkg::IRQ_UNDERFLOW_BIT]));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irqStatus_r <= 1'b0;
      irqMask_r <= 1'b0;
    end else begin
      irqStatus_r <= irqNxt;
      if (req.wr && selMask) begin
        irqMask_r <= req.wdata[evt_timer_pkg::IRQ_UNDERFLOW_BIT];
      end
    end
  end

  assign timerIrq = irqStatus_r & irqMask_r;

  //////////////////////////////////////////////////////////////////////////////
  // read path, one cycle latency, unmapped reads as zero
  assign rdMux = selCtrl ? {29'h0, 1'b0, run_r, run_r} :
                 selIoc ? {26'h0, ioCfg_r.filtHigh, ioCfg_r.filtLow, ioCfg_r.pinSel, ioCfg_r.outEnable, 1'b0,
                           ioCfg_r.edgeSel} :
                 selMode ? 32'h0 :
                 selPre ? {24'h0, preCount} :
                 selMain ? {24'h0, mainCount} :
                 selStat ? {31'h0, irqStatus_r} :
                 selMask ? {31'h0, irqMask_r} :
                 selPort ? {31'h0, portOut_r} : 32'h0;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= req.rd ? rdMux : 32'h0;
    end
  end

  assign regRdata = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  AST_RUN_START: assert property (@(posedge ref_clk) disable iff (!resetn)
    (regWr && selCtrl && regWdata[0] && !regWdata[2]) |=> run_r)
    else $error("run bit write did not start counting");
  AST_RUN_HALT: assert property (@(posedge ref_clk) disable iff (!resetn)
    (regWr && selCtrl && !regWdata[0]) |=> !run_r)
    else $error("run bit clear did not halt counting");
  AST_FORCE_STOP: assert property (@(posedge ref_clk) disable iff (!resetn)
    (regWr && selCtrl && regWdata[2]) |=> !run_r)
    else $error("force stop did not halt counting");
  AST_NO_COUNT_STOPPED: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!run_r && !wrPre) |=> $stable(preCount))
    else $error("prescaler moved while stopped");
  AST_PRE_DEC: assert property (@(posedge ref_clk) disable iff (!resetn)
    (preTick && !wrPre && preCount != 8'h00) |=> (preCount == $past(preCount) - 8'h01))
    else $error("prescaler did not decrement on event");
  AST_MAIN_STEP: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!preUnder && !wrMain) |=> $stable(mainCount))
    else $error("main counter moved without prescaler underflow");
  AST_LOAD: assert property (@(posedge ref_clk) disable iff (!resetn)
    wrMain |=> (mainCount == $past(regWdata[7:0])))
    else $error("main count write not loaded");
  AST_IRQ_SET: assert property (@(posedge ref_clk) disable iff (!resetn)
    mainUnder |=> irqStatus_r)
    else $error("underflow did not set interrupt status");
  AST_TOGGLE: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mainUnder && !(regWr && selMode)) |=> (pulseLevel_r != $past(pulseLevel_r)))
    else $error("pulse output did not toggle on underflow");
  AST_MODE_LEVEL: assert property (@(posedge ref_clk) disable iff (!resetn)
    (regWr && selMode) |=> pulseLevel_r)
    else $error("mode write did not set starting level");

  //////////////////////////////////////////////////////////////////////////////
  default clocking dcAst @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // run control
  AST_RUN_HOLD: assert property (
    !wrCtrl |=> $stable(run_r))
    else $error("run state moved without control write");
  AST_RUN_READ: assert property (
    (regRd && selCtrl) |=> (regRdata[1:0] == {2{$past(run_r)}}))
    else $error("control read does not show run state");
  AST_STOP_NO_UNDER: assert property (
    !run_r |-> !preUnder)
    else $error("prescaler underflow while stopped");
  AST_MAIN_HALT: assert property (
    (!run_r && !wrMain) |=> $stable(mainCount))
    else $error("main counter moved while stopped");
  AST_FORCE_NO_TICK: assert property (
    (regWr && selCtrl && regWdata[2]) |=> !preTick)
    else $error("event counted after force stop");

  // event input
  AST_EDGE_LEVEL: assert property (
    evtPulse |-> (evtLevel == !ioCfg_r.edgeSel))
    else $error("event pulse on the wrong edge");
  AST_PULSE_ONE: assert property (
    (evtPulse && !(regWr && selIoc)) |=> !evtPulse)
    else $error("event pulse longer than one cycle");
  AST_RAW_A: assert property (
    (!ioCfg_r.filtLow && !ioCfg_r.filtHigh && !ioCfg_r.pinSel) |=> (evtLevel == $past(portPinAltA)))
    else $error("unfiltered level does not follow first pin");
  AST_RAW_B: assert property (
    (!ioCfg_r.filtLow && !ioCfg_r.filtHigh && ioCfg_r.pinSel) |=> (evtLevel == $past(portPinAltB)))
    else $error("unfiltered level does not follow second pin");
  AST_EXT_LINE: assert property (
    (!run_r && !ioCfg_r.filtLow && !ioCfg_r.filtHigh && !ioCfg_r.pinSel) |=>
    (externalInterruptLine == $past(portPinAltA)))
    else $error("external interrupt line lost while stopped");

  // counters
  AST_PRE_UNDER_ZERO: assert property (
    preUnder |-> (preCount == 8'h00))
    else $error("prescaler underflow away from zero");
  AST_MAIN_UNDER_ZERO: assert property (
    mainUnder |-> (preUnder && mainCount == 8'h00))
    else $error("main underflow without prescaler underflow at zero");
  AST_MAIN_DEC: assert property (
    (preUnder && !wrMain && mainCount != 8'h00) |=> (mainCount == $past(mainCount) - 8'h01))
    else $error("main counter did not step on prescaler underflow");
  AST_PRE_LOAD: assert property (
    wrPre |=> (preCount == $past(regWdata[7:0])))
    else $error("prescaler write not loaded");
  AST_MAIN_LOAD_RUN: assert property (
    (wrMain && run_r) |=> (mainCount == $past(regWdata[7:0])))
    else $error("main write while running not loaded");
  AST_PRE_HOLD: assert property (
    (!preTick && !wrPre) |=> $stable(preCount))
    else $error("prescaler moved without event");

  // pulse pin and port
  AST_PULSE_HOLD: assert property (
    (!mainUnder && !(regWr && selMode)) |=> $stable(pulseLevel_r))
    else $error("pulse level moved without underflow");
  AST_PIN_PULSE: assert property (
    (ioCfg_r.outEnable && mainUnder && !(regWr && selMode) && !(regWr && selIoc)) |=>
    (invertedPulsePin != $past(invertedPulsePin)))
    else $error("pulse pin did not toggle on underflow");
  AST_PIN_PORT: assert property (
    (!ioCfg_r.outEnable && !(regWr && selIoc) && !(regWr && selPort)) |=> $stable(invertedPulsePin))
    else $error("port pin moved without port write");
  AST_PORT_WRITE: assert property (
    (regWr && selPort) |=> (portOut_r == $past(regWdata[0])))
    else $error("port write not taken");
  AST_MODE_PIN: assert property (
    (regWr && selMode && ioCfg_r.outEnable) |=> invertedPulsePin)
    else $error("mode write did not set pulse pin level");

  // interrupt
  AST_IRQ_CLEAR: assert property (
    (regWr && selStat && regWdata[0] && !mainUnder) |=> !irqStatus_r)
    else $error("status clear not taken");
  AST_IRQ_HOLD: assert property (
    (irqStatus_r && !(regWr && selStat)) |=> irqStatus_r)
    else $error("status dropped without clear");
  AST_IRQ_QUIET: assert property (
    (!irqStatus_r && !mainUnder) |=> !irqStatus_r)
    else $error("status set without underflow");
  AST_IRQ_MASKED: assert property (
    !irqMask_r |-> !timerIrq)
    else $error("masked interrupt raised");
  AST_IRQ_RAISE: assert property (
    (mainUnder && irqMask_r && !(regWr && selMask)) |=> timerIrq)
    else $error("unmasked underflow did not raise interrupt");
  AST_MASK_HOLD: assert property (
    !(regWr && selMask) |=> $stable(irqMask_r))
    else $error("mask moved without write");

  // read path and io control register
  AST_RD_IDLE: assert property (
    !regRd |=> (regRdata == 32'h0))
    else $error("read data not zero outside read");
  AST_RD_PRE: assert property (
    (regRd && selPre) |=> (regRdata == {24'h0, $past(preCount)}))
    else $error("prescaler read mismatch");
  AST_RD_MAIN: assert property (
    (regRd && selMain) |=> (regRdata == {24'h0, $past(mainCount)}))
    else $error("main read mismatch");
  AST_RD_STAT: assert property (
    (regRd && selStat) |=> (regRdata == {31'h0, $past(irqStatus_r)}))
    else $error("status read mismatch");
  AST_IOC_HOLD: assert property (
    !(regWr && selIoc) |=> $stable(ioCfg_r))
    else $error("io control moved without write");
  AST_IOC_READ: assert property (
    (regRd && selIoc) |=> (regRdata[3] == $past(ioCfg_r.pinSel)))
    else $error("pin select read mismatch");
endmodule : event_counter_timer

// file: verification/evt_source_model.sv
// event source model: toggles the chosen pin with a set gap while the other pin chatters
`timescale 1ns/1ps
module evt_source_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic useB,
  input wire logic [7:0] nToggles,
  input wire logic [7:0] gap,
  output logic pinA,
  output logic pinB,
  output logic busy
);
  logic [7:0] left;
  logic [7:0] cnt;
  logic onB;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pinA <= 1'b0;
      pinB <= 1'b0;
      busy <= 1'b0;
      left <= 8'h00;
      cnt <= 8'h00;
      onB <= 1'b0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      left <= nToggles;
      cnt <= gap;
      onB <= useB;
    end else if (busy) begin
      // unselected pin chatters so a wrong pin choice shows as extra counts
      if (onB) pinA <= ~pinA; else pinB <= ~pinB;
      if (cnt == 8'h00) begin
        if (onB) pinB <= ~pinB; else pinA <= ~pinA;
        cnt <= gap;
        left <= left - 8'h01;
        busy <= (left != 8'h01);
      end else begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : evt_source_model

// file: verification/event_counter_timer_tb_top.sv
// testbench: event counter timer driven by the event source model
`timescale 1ns/1ps
module event_counter_timer_tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic pinA, pinB, extLine, pulsePin, pulseOe, timerIrq, srcBusy;
  logic srcGo = 1'b0;
  logic srcB = 1'b0;
  logic [7:0] srcN = 8'h00;
  logic [7:0] srcGap = 8'h00;
  logic [31:0] seed = 32'h8aef;
  logic [31:0] expQ[$];
  string nameQ[$];
  logic rdSeen = 1'b0;
  int nMismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int k;
  always #50 ref_clk = ~ref_clk;
  event_counter_timer uut (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .portPinAltA(pinA), .portPinAltB(pinB),
    .externalInterruptLine(extLine), .invertedPulsePin(pulsePin), .invertedPulseOe(pulseOe),
    .timerIrq(timerIrq));
  evt_source_model src (.ref_clk(ref_clk), .resetn(resetn), .start(srcGo), .useB(srcB), .nToggles(srcN),
    .gap(srcGap), .pinA(pinA), .pinB(pinB), .busy(srcBusy));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task cmpWord(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin nMismatch++; $display("FAIL %s expected %h seen %h", nm, e, g); end
  endtask : cmpWord
  task cmpBit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin nMismatch++; $display("FAIL %s expected %b seen %b", nm, e, g); end
  endtask : cmpBit
  task testDone;
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : testDone
  // write, then settle to the falling edge so outputs can be sampled
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a; regWdata <= d; regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge ref_clk);
    regAddr <= a; regRd <= 1'b1;
    expQ.push_back(e); nameQ.push_back(nm);
    @(posedge ref_clk);
    regRd <= 1'b0;
  endtask : rd
  task ev(input logic b, input logic [7:0] n, input logic [7:0] g);
    int i;
    @(posedge ref_clk);
    srcB <= b; srcN <= n; srcGap <= g; srcGo <= 1'b1;
    @(posedge ref_clk);
    srcGo <= 1'b0;
    @(posedge ref_clk);
    for (i = 0; i < 5000 && srcBusy === 1'b1; i++) @(posedge ref_clk);
    repeat (150) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : ev
  ////////////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rdSeen) cmpWord(nameQ.pop_front(), expQ.pop_front(), regRdata);
    rdSeen <= regRd;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin nMismatch++; testDone(); end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(evt_timer_pkg::OFF_PRESCALE, 32'hff, "pre rst");
    rd(evt_timer_pkg::OFF_MAIN, 32'hff, "main rst");
    rd(evt_timer_pkg::OFF_IOCTRL, 32'h0, "ioctrl rst");
    rd(8'h20, 32'h0, "unmapped");
    wr(evt_timer_pkg::OFF_PRESCALE, 32'h1);
    wr(evt_timer_pkg::OFF_MAIN, 32'h2);
    rd(evt_timer_pkg::OFF_PRESCALE, 32'h1, "pre load");
    rd(evt_timer_pkg::OFF_MAIN, 32'h2, "main load");
    wr(evt_timer_pkg::OFF_CTRL, 32'h1);
    rd(evt_timer_pkg::OFF_CTRL, 32'h3, "ctrl run");
    ev(1'b0, 8'h06, 8'h03);
    rd(evt_timer_pkg::OFF_PRESCALE, 32'h0, "pre mid");
    rd(evt_timer_pkg::OFF_MAIN, 32'h1, "main mid");
    cmpBit("irq idle", 1'b0, timerIrq);
    ev(1'b0, 8'h06, 8'h03);
    rd(evt_timer_pkg::OFF_PRESCALE, 32'h1, "pre reload");
    rd(evt_timer_pkg::OFF_MAIN, 32'h2, "main reload");
    rd(evt_timer_pkg::OFF_IRQ_STATUS, 32'h1, "status set");
    cmpBit("irq masked", 1'b0, timerIrq);
    wr(evt_timer_pkg::OFF_IRQ_MASK, 32'h1);
    cmpBit("irq unmasked", 1'b1, timerIrq);
    wr(evt_timer_pkg::OFF_IRQ_STATUS, 32'h1);
    cmpBit("irq cleared", 1'b0, timerIrq);
    rd(evt_timer_pkg::OFF_IRQ_STATUS, 32'h0, "status clr");
    wr(evt_timer_pkg::OFF_IOCTRL, 32'h1);
    ev(1'b0, 8'h01, 8'h03);
    cmpBit("ext line", 1'b1, extLine);
    rd(evt_timer_pkg::OFF_PRESCALE, 32'h1, "pre rise ignored");
    ev(1'b0, 8'h01, 8'h03);
    rd(evt_timer_pkg::OFF_PRESCALE, 32'h0, "pre fall");
    wr(evt_timer_pkg::OFF_CTRL, 32'h0);
    ev(1'b0, 8'h04, 8'h03);
    rd(evt_timer_pkg::OFF_PRESCALE, 32'h0, "pre halted");
    rd(evt_timer_pkg::OFF_CTRL, 32'h0, "ctrl halted");
    wr(evt_timer_pkg::OFF_CTRL, 32'h1);
    wr(evt_timer_pkg::OFF_CTRL, 32'h5);
    ev(1'b0, 8'h04, 8'h03);
    rd(evt_timer_pkg::OFF_PRESCALE, 32'h0, "pre forced");
    rd(evt_timer_pkg::OFF_CTRL, 32'h0, "ctrl forced");
    wr(evt_timer_pkg::OFF_IOCTRL, 32'hc);
    wr(evt_timer_pkg::OFF_MODE, 32'h0);
    cmpBit("pulse start", 1'b1, pulsePin);
    cmpBit("pulse oe", 1'b1, pulseOe);
    wr(evt_timer_pkg::OFF_CTRL, 32'h1);
    ev(1'b1, 8'h0a, 8'h03);
    rd(evt_timer_pkg::OFF_PRESCALE, 32'h1, "pre pin b");
    rd(evt_timer_pkg::OFF_MAIN, 32'h2, "main pin b");
    cmpBit("pulse toggled", 1'b0, pulsePin);
    cmpBit("irq again", 1'b1, timerIrq);
    wr(evt_timer_pkg::OFF_IOCTRL, 32'h8);
    wr(evt_timer_pkg::OFF_PORT_OUT, 32'h1);
    cmpBit("port high", 1'b1, pulsePin);
    wr(evt_timer_pkg::OFF_PORT_OUT, 32'h0);
    cmpBit("port low", 1'b0, pulsePin);
    seed = xorshift(seed);
    wr(evt_timer_pkg::OFF_PRESCALE, {24'h0, seed[7:0]});
    rd(evt_timer_pkg::OFF_PRESCALE, {24'h0, seed[7:0]}, "pre live");
    seed = xorshift(seed);
    wr(evt_timer_pkg::OFF_MAIN, {24'h0, seed[7:0]});
    rd(evt_timer_pkg::OFF_MAIN, {24'h0, seed[7:0]}, "main live");
    wr(evt_timer_pkg::OFF_PRESCALE, 32'h5);
    wr(evt_timer_pkg::OFF_MAIN, 32'h5);
    // each filter rate: a one-cycle glitch is dropped, a long pulse counts once
    for (k = 1; k < 4; k++) begin
      wr(evt_timer_pkg::OFF_IOCTRL, {26'h0, k[1:0], 4'h8});
      ev(1'b1, 8'h02, 8'h00);
      rd(evt_timer_pkg::OFF_PRESCALE, 32'(6 - k), "pre glitch");
      ev(1'b1, 8'h02, 8'hc8);
      rd(evt_timer_pkg::OFF_PRESCALE, 32'(5 - k), "pre filtered");
    end
    repeat (3) @(posedge ref_clk);
    testDone();
  end
endmodule : event_counter_timer_tb_top
